// ### rtl/ptu_consts.svh
/*
  Register offsets, field positions and reset values of the pulse-train unit.
  Assumes byte addresses on a 32-bit Wishbone bus, 4 KiB window per unit.
*/
`ifndef PTU_CONSTS_SVH
`define PTU_CONSTS_SVH
// Register byte offsets (per-channel strides are 8 and 4)
`define PTU_CONF0_OFS 12'h020
`define PTU_CONF1_OFS 12'h024
`define PTU_INT_RAW_OFS 12'h0A0
`define PTU_INT_ST_OFS 12'h0A4
`define PTU_INT_ENA_OFS 12'h0A8
`define PTU_INT_CLR_OFS 12'h0AC
`define PTU_CARRIER_OFS 12'h0B0
`define PTU_TX_LIM_OFS 12'h0D0
`define PTU_UNIT_CONF_OFS 12'h0F0
`define PTU_RAM_OFS 12'h800
// Conf0 fields
`define PTU_F_DIV 7:0
`define PTU_F_IDLE_THR 23:8
`define PTU_F_MEM_BLK 27:24
`define PTU_B_CARRIER_EN 28
// Conf1 fields
`define PTU_B_TX_BEGIN 0
`define PTU_B_RX_ENABLE 1
`define PTU_B_OWNER 2
`define PTU_B_REPEAT 3
`define PTU_B_FILT_EN 4
`define PTU_F_FILT_THR 12:5
`define PTU_B_BASE_SEL 13
`define PTU_B_IDLE_OE 14
`define PTU_B_IDLE_LV 15
`define PTU_B_TX_BUSY 16
`define PTU_B_RX_BUSY 17
// Unit-wide conf fields
`define PTU_B_RAM_PD 0
`define PTU_B_WRAP_EN 1
// Reset values
`define PTU_CONF0_RST 32'h0100_0001
`define PTU_CONF1_RST 32'h0000_2000
`define PTU_CARRIER_RST 32'h0040_0040
`define PTU_LIM_RST 9'h080
`endif

// ### rtl/ptu_pkg.sv
/*
  Types of the pulse-train unit.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ptu_pkg;
  typedef enum logic {PTU_TX_IDLE, PTU_TX_RUN} ptu_tx_e;
  typedef enum logic {PTU_RX_IDLE, PTU_RX_RUN} ptu_rx_e;
  typedef logic [15:0] ptu_entry_t;
endpackage

// ### rtl/ptu_top.sv
/*
  Eight-channel pulse-train transmitter/receiver with shared 512x32 RAM,
  reached over a classic Wishbone slave. Assumes i_ref_tick and i_pulse_in
  are asynchronous pins; everything else is on i_mclk.
*/
// The Wishbone slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "ptu_consts.svh"

// Notes on behaviour
// - Eight channels, each with transmitter and receiver, one active at a time.
// - One shared 512x32 RAM: bus reads/writes, transmitters read, receivers write.
// - Each RAM word holds two 16-bit entries of level and period.
// - Zero period marks the end: transmitter stops, receiver writes one at idle.
// - RAM sits at 0x800, eight 64-word blocks, channel n starts at block n.
// - Block count above one extends into following blocks, wrapping modulo 512.
// - Ownership bit per channel; a violating access raises the channel error event.
// - Ownership 1 means receiver owns the RAM, 0 means transmitter.
// - Per-channel select picks bus clock or reference tick as base clock.
// - Select 1 picks the bus clock, 0 the reference tick.
// - An 8-bit divider makes the channel clock for carrier and duration counter.
// - While tx begin is 1 the transmitter fetches words and plays their entries.
// - Lower entry of a word plays first, upper entry second.
// - Wraparound mode continues from the first entry without a gap.
// - Threshold event when events sent equals the transmit limit.
// - Zero-length entry ends transmission, raises done event, returns to idle.
// - Repeat mode restarts from the start instead of going idle.
// - Idle output follows idle output enable and idle level.
// - Carrier enable modulates output; high and low lengths in channel ticks.
// - Receiver measures time between edges, writes entries in transmit format.
// - Input quiet beyond idle threshold: write zero entry, done event, go idle.
// - Filter discards pulses shorter than threshold in bus clock periods.
// - Power-down bit puts the RAM in low power.
module ptu_top import ptu_pkg::*; #(
  parameter int CHANNELS = 8,
  parameter int RAM_WORDS = 512
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Pins
  input wire logic i_ref_tick,
  input wire logic [7:0] i_pulse_in,
  output logic [7:0] o_pulse_out,
  output logic [7:0] o_pulse_en
);

  // Logic is built for exactly eight channels sharing 512 words
  if (CHANNELS != 8 || RAM_WORDS != 512) begin : g_bad_cfg
    $error("ptu_top supports only 8 channels and 512 RAM words");
  end

  // Shared storage and configuration
  logic [31:0] ram [RAM_WORDS];
  logic [31:0] conf0_q [8];
  logic [31:0] conf1_q [8];
  logic [31:0] car_q [8];
  logic [8:0] lim_q [8];
  logic [1:0] unit_q;
  logic [31:0] raw_q, ena_q;
  logic [31:0] ev_set;
  // Per-channel requests towards the shared logic
  logic [7:0] tx_clr, rx_clr, tx_busy, rx_busy, wr_grant;
  logic [7:0] ev_txd, ev_rxd, ev_err, ev_thr, pend_v;
  logic [31:0] pend_word [8];
  logic [8:0] pend_addr [8];
  logic [2:0] slot_q;
  logic [1:0] ref_sync_q;
  logic ref_d1_q, ref_pulse;

  // Bus handshake; ack one cycle after the request, writes on the ack edge
  logic req, wr_fire;
  logic [31:0] rd_d;
  assign req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr_fire = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

  function automatic logic [31:0] bmerge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
    bmerge = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) bmerge[8*b +: 8] = n[8*b +: 8];
    end
  endfunction

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (i_wb_adr[11]) begin
      if (!unit_q[`PTU_B_RAM_PD]) rd_d = ram[i_wb_adr[10:2]];
    end else begin
      for (int c = 0; c < 8; c++) begin
        if (i_wb_adr == `PTU_CONF0_OFS + 12'(8 * c)) rd_d = conf0_q[c];
        if (i_wb_adr == `PTU_CONF1_OFS + 12'(8 * c)) begin
          rd_d = conf1_q[c];
          rd_d[`PTU_B_TX_BUSY] = tx_busy[c];
          rd_d[`PTU_B_RX_BUSY] = rx_busy[c];
        end
        if (i_wb_adr == `PTU_CARRIER_OFS + 12'(4 * c)) rd_d = car_q[c];
        if (i_wb_adr == `PTU_TX_LIM_OFS + 12'(4 * c)) rd_d = {23'h0, lim_q[c]};
      end
      if (i_wb_adr == `PTU_INT_RAW_OFS) rd_d = raw_q;
      if (i_wb_adr == `PTU_INT_ST_OFS) rd_d = raw_q & ena_q;
      if (i_wb_adr == `PTU_INT_ENA_OFS) rd_d = ena_q;
      if (i_wb_adr == `PTU_UNIT_CONF_OFS) rd_d = {30'h0, unit_q};
    end
  end

  // Ack and read data registered together
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= req;
      if (req) o_wb_dat <= rd_d;
    end
  end

  // Configuration registers; software write wins over a hardware clear
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      for (int c = 0; c < 8; c++) begin
        conf0_q[c] <= `PTU_CONF0_RST;
        conf1_q[c] <= `PTU_CONF1_RST;
        car_q[c] <= `PTU_CARRIER_RST;
        lim_q[c] <= `PTU_LIM_RST;
      end
      unit_q <= 2'h0;
      ena_q <= 32'h0000_0000;
    end else begin
      for (int c = 0; c < 8; c++) begin
        if (tx_clr[c]) conf1_q[c][`PTU_B_TX_BEGIN] <= 1'b0;
        if (rx_clr[c]) conf1_q[c][`PTU_B_RX_ENABLE] <= 1'b0;
        if (wr_fire && i_wb_adr == `PTU_CONF0_OFS + 12'(8 * c))
          conf0_q[c] <= bmerge(conf0_q[c], i_wb_dat, i_wb_sel);
        if (wr_fire && i_wb_adr == `PTU_CONF1_OFS + 12'(8 * c))
          conf1_q[c][15:0] <= 16'(bmerge({16'h0, conf1_q[c][15:0]}, i_wb_dat, i_wb_sel));
        if (wr_fire && i_wb_adr == `PTU_CARRIER_OFS + 12'(4 * c))
          car_q[c] <= bmerge(car_q[c], i_wb_dat, i_wb_sel);
        if (wr_fire && i_wb_adr == `PTU_TX_LIM_OFS + 12'(4 * c))
          lim_q[c] <= 9'(bmerge({23'h0, lim_q[c]}, i_wb_dat, i_wb_sel));
      end
      if (wr_fire && i_wb_adr == `PTU_UNIT_CONF_OFS && i_wb_sel[0])
        unit_q <= i_wb_dat[1:0];
      if (wr_fire && i_wb_adr == `PTU_INT_ENA_OFS)
        ena_q <= bmerge(ena_q, i_wb_dat, i_wb_sel);
    end
  end

  // Sticky events: tx done 3n, rx done 3n+1, error 3n+2, threshold 24+n
  always_comb begin
    ev_set = 32'h0000_0000;
    for (int c = 0; c < 8; c++) begin
      ev_set[3 * c] = ev_txd[c];
      ev_set[3 * c + 1] = ev_rxd[c];
      ev_set[3 * c + 2] = ev_err[c];
      ev_set[24 + c] = ev_thr[c];
    end
  end

  // A set in the clearing cycle survives
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      raw_q <= 32'h0000_0000;
    end else if (wr_fire && i_wb_adr == `PTU_INT_CLR_OFS) begin
      raw_q <= (raw_q & ~bmerge(32'h0, i_wb_dat, i_wb_sel)) | ev_set;
    end else begin
      raw_q <= raw_q | ev_set;
    end
  end

  // RAM write port: bus first, else the channel owning the current slot
  always_ff @(posedge i_mclk) begin
    if (!unit_q[`PTU_B_RAM_PD]) begin
      if (wr_fire && i_wb_adr[11])
        ram[i_wb_adr[10:2]] <= bmerge(ram[i_wb_adr[10:2]], i_wb_dat, i_wb_sel);
      else if (pend_v[slot_q])
        ram[pend_addr[slot_q]] <= pend_word[slot_q];
    end
  end

  // Round-robin slot; a channel waits up to eight cycles for its slot, eight more each time a bus array write takes that slot
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) slot_q <= 3'h0;
    else slot_q <= slot_q + 3'h1;
  end

  for (genvar g = 0; g < 8; g++) begin : g_grant
    assign wr_grant[g] = (slot_q == 3'(g)) & pend_v[g] & ~(wr_fire & i_wb_adr[11]);
  end

  // Reference tick crossing; only the second stage feeds the edge detector
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      ref_sync_q <= 2'b00;
      ref_d1_q <= 1'b0;
    end else begin
      ref_sync_q <= {ref_sync_q[0], i_ref_tick};
      ref_d1_q <= ref_sync_q[1];
    end
  end
  assign ref_pulse = ref_sync_q[1] & ~ref_d1_q;

  // One channel per iteration
  for (genvar n = 0; n < 8; n++) begin : g_ch
    ptu_tx_e tx_st_q;
    ptu_rx_e rx_st_q;
    logic [7:0] div_cnt_q, flt_cnt_q;
    logic tick, base, last, end_mark, in_sync1_q, in_sync2_q, flt_q, prev_q, cph_q;
    logic [9:0] start_e, size_e, tx_ptr_q, rx_ptr_q;
    logic [14:0] tx_cnt_q, rx_cnt_q;
    logic [8:0] ev_cnt_q;
    logic [15:0] car_cnt_q;
    ptu_entry_t cur, half_q, emit;
    logic [31:0] rdw;
    logic do_emit, rx_end, rx_arm_q;
    logic [3:0] blk;

    // Channel range in entries, start block n, wraps modulo the RAM
    assign blk = (conf0_q[n][`PTU_F_MEM_BLK] == 4'h0) ? 4'h1 : conf0_q[n][`PTU_F_MEM_BLK];
    assign start_e = 10'(n * 128);
    assign size_e = (blk >= 4'h8) ? 10'h000 : {blk[2:0], 7'h00};
    assign last = (10'(tx_ptr_q + 10'h1 - start_e) == size_e);

    // Base clock choice and 8-bit divider; divide value 0 means 256
    assign base = conf1_q[n][`PTU_B_BASE_SEL] ? 1'b1 : ref_pulse;
    assign tick = base && (div_cnt_q == conf0_q[n][7:0] - 8'h01);
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) div_cnt_q <= 8'h00;
      else if (tick) div_cnt_q <= 8'h00;
      else if (base) div_cnt_q <= div_cnt_q + 8'h01;
    end

    // Current transmit entry, lower half first
    assign rdw = unit_q[`PTU_B_RAM_PD] ? 32'h0 : ram[tx_ptr_q[9:1]];
    assign cur = tx_ptr_q[0] ? rdw[31:16] : rdw[15:0];
    assign end_mark = (cur[14:0] == 15'h0000);

    // Transmit sequencer
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        tx_st_q <= PTU_TX_IDLE;
        tx_ptr_q <= 10'h000;
        tx_cnt_q <= 15'h0000;
        ev_cnt_q <= 9'h000;
      end else if (tx_st_q == PTU_TX_IDLE) begin
        if (conf1_q[n][`PTU_B_TX_BEGIN] && !conf1_q[n][`PTU_B_OWNER] && rx_st_q == PTU_RX_IDLE) begin
          tx_st_q <= PTU_TX_RUN;
          tx_ptr_q <= start_e;
          tx_cnt_q <= 15'h0000;
          ev_cnt_q <= 9'h000;
        end
      end else if (conf1_q[n][`PTU_B_OWNER] || !conf1_q[n][`PTU_B_TX_BEGIN]) begin
        tx_st_q <= PTU_TX_IDLE; // ownership lost or start withdrawn
      end else if (tick) begin
        if (end_mark || (last && !unit_q[`PTU_B_WRAP_EN])) begin
          tx_ptr_q <= start_e;
          tx_cnt_q <= 15'h0000;
          ev_cnt_q <= 9'h000;
          if (!conf1_q[n][`PTU_B_REPEAT]) tx_st_q <= PTU_TX_IDLE;
        end else if (tx_cnt_q + 15'h0001 >= cur[14:0]) begin
          tx_ptr_q <= last ? start_e : tx_ptr_q + 10'h001;
          tx_cnt_q <= 15'h0000;
          ev_cnt_q <= ev_cnt_q + 9'h001;
        end else begin
          tx_cnt_q <= tx_cnt_q + 15'h0001;
        end
      end
    end

    // Transmit events and hardware clear of the start bit
    assign ev_txd[n] = (tx_st_q == PTU_TX_RUN) && tick && (end_mark ||
                       (last && !unit_q[`PTU_B_WRAP_EN])) && conf1_q[n][`PTU_B_TX_BEGIN] &&
                       !conf1_q[n][`PTU_B_OWNER];
    assign ev_thr[n] = (tx_st_q == PTU_TX_RUN) && tick && !ev_txd[n] && !end_mark &&
                       (tx_cnt_q + 15'h0001 >= cur[14:0]) &&
                       (ev_cnt_q + 9'h001 == lim_q[n]);
    assign tx_clr[n] = (ev_txd[n] && !conf1_q[n][`PTU_B_REPEAT]) ||
                       (conf1_q[n][`PTU_B_TX_BEGIN] && conf1_q[n][`PTU_B_OWNER]);
    assign tx_busy[n] = (tx_st_q == PTU_TX_RUN);

    // Carrier phase counter on the channel clock
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        car_cnt_q <= 16'h0000;
        cph_q <= 1'b1;
      end else if (tx_st_q == PTU_TX_IDLE) begin
        car_cnt_q <= 16'h0000;
        cph_q <= 1'b1;
      end else if (tick) begin
        if (car_cnt_q + 16'h0001 >= (cph_q ? car_q[n][15:0] : car_q[n][31:16])) begin
          cph_q <= ~cph_q;
          car_cnt_q <= 16'h0000;
        end else begin
          car_cnt_q <= car_cnt_q + 16'h0001;
        end
      end
    end

    // Output pin; idle drives the idle settings
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        o_pulse_out[n] <= 1'b0;
        o_pulse_en[n] <= 1'b0;
      end else if (tx_st_q == PTU_TX_RUN && !end_mark) begin
        // End marker is never played; the pin goes idle at once
        o_pulse_out[n] <= cur[15] & (~conf0_q[n][`PTU_B_CARRIER_EN] | cph_q);
        o_pulse_en[n] <= 1'b1;
      end else begin
        o_pulse_out[n] <= conf1_q[n][`PTU_B_IDLE_OE] & conf1_q[n][`PTU_B_IDLE_LV];
        o_pulse_en[n] <= conf1_q[n][`PTU_B_IDLE_OE];
      end
    end

    // Input crossing and glitch filter counted in bus clocks
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        in_sync1_q <= 1'b0;
        in_sync2_q <= 1'b0;
        flt_q <= 1'b0;
        flt_cnt_q <= 8'h00;
      end else begin
        in_sync1_q <= i_pulse_in[n];
        in_sync2_q <= in_sync1_q;
        if (!conf1_q[n][`PTU_B_FILT_EN] || in_sync2_q == flt_q) begin
          flt_q <= conf1_q[n][`PTU_B_FILT_EN] ? flt_q : in_sync2_q;
          flt_cnt_q <= 8'h00;
        end else if (flt_cnt_q + 8'h01 >= conf1_q[n][`PTU_F_FILT_THR]) begin
          flt_q <= in_sync2_q;
          flt_cnt_q <= 8'h00;
        end else begin
          flt_cnt_q <= flt_cnt_q + 8'h01;
        end
      end
    end

    // Receive entry on each edge after the first, end marker once the input goes quiet
    assign rx_end = tick && ({1'b0, rx_cnt_q} > conf0_q[n][`PTU_F_IDLE_THR]);
    assign do_emit = (rx_st_q == PTU_RX_RUN) && ((flt_q != prev_q && rx_arm_q) || rx_end);
    assign emit = rx_end ? {prev_q, 15'h0000} :
                  {prev_q, (rx_cnt_q == 15'h0000) ? 15'h0001 : rx_cnt_q};
    assign rx_busy[n] = (rx_st_q == PTU_RX_RUN);
    assign ev_rxd[n] = (rx_st_q == PTU_RX_RUN) && rx_end;
    assign rx_clr[n] = ev_rxd[n] || (conf1_q[n][`PTU_B_RX_ENABLE] && !conf1_q[n][`PTU_B_OWNER]);
    assign ev_err[n] = (conf1_q[n][`PTU_B_TX_BEGIN] && conf1_q[n][`PTU_B_OWNER]) ||
                       (conf1_q[n][`PTU_B_RX_ENABLE] && !conf1_q[n][`PTU_B_OWNER]);

    // Receive sequencer
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        rx_st_q <= PTU_RX_IDLE;
        rx_ptr_q <= 10'h000;
        rx_cnt_q <= 15'h0000;
        prev_q <= 1'b0;
        half_q <= 16'h0000;
        rx_arm_q <= 1'b0;
      end else if (rx_st_q == PTU_RX_IDLE) begin
        if (conf1_q[n][`PTU_B_RX_ENABLE] && conf1_q[n][`PTU_B_OWNER] && tx_st_q == PTU_TX_IDLE) begin
          rx_st_q <= PTU_RX_RUN;
          rx_ptr_q <= start_e;
          rx_cnt_q <= 15'h0000;
          prev_q <= flt_q;
          rx_arm_q <= 1'b0;
        end
      end else if (!conf1_q[n][`PTU_B_RX_ENABLE] || !conf1_q[n][`PTU_B_OWNER]) begin
        rx_st_q <= PTU_RX_IDLE;
      end else begin
        if (do_emit) begin
          if (!rx_ptr_q[0]) half_q <= emit;
          rx_ptr_q <= (10'(rx_ptr_q + 10'h1 - start_e) == size_e) ? start_e :
                      rx_ptr_q + 10'h001;
          prev_q <= flt_q;
          rx_cnt_q <= 15'h0000;
        end else if (flt_q != prev_q) begin
          // First edge only starts timing; the quiet lead-in is not a pulse
          prev_q <= flt_q;
          rx_cnt_q <= 15'h0000;
          rx_arm_q <= 1'b1;
        end else if (tick && rx_cnt_q != 15'h7FFF) begin
          rx_cnt_q <= rx_cnt_q + 15'h0001;
        end
        if (rx_end) rx_st_q <= PTU_RX_IDLE;
      end
    end

    // Pending word; a new word in the grant cycle keeps the flag set
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        pend_v[n] <= 1'b0;
        pend_word[n] <= 32'h0000_0000;
        pend_addr[n] <= 9'h000;
      end else if (do_emit && (rx_ptr_q[0] || rx_end)) begin
        pend_v[n] <= 1'b1;
        pend_word[n] <= rx_ptr_q[0] ? {emit, half_q} : {16'h0000, emit};
        pend_addr[n] <= rx_ptr_q[9:1];
      end else if (wr_grant[n]) begin
        pend_v[n] <= 1'b0;
      end
    end
  end

endmodule // ptu_top

// ### testbench/ptu_checker.sv
/*
  Concurrent checks on the pulse-train unit's ports.
  Assumes a single clock i_mclk and the asynchronous active-high reset i_rst.
*/
`timescale 1ns/1ps
module ptu_checker #(
  parameter int CHANNELS = 8,
  parameter int RAM_WORDS = 512
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Wishbone slave side
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Pins
  input wire logic i_ref_tick,
  input wire logic [7:0] i_pulse_in,
  input wire logic [7:0] o_pulse_out,
  input wire logic [7:0] o_pulse_en
);
  logic pd_q;
  logic c0w_q;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  // Shadow of power-down and of the first conf0 write, taken at the ack edge
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      pd_q <= 1'b0;
      c0w_q <= 1'b0;
    end else if (i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack) begin
      if (i_wb_adr == 12'h0F0 && i_wb_sel[0]) pd_q <= i_wb_dat[0];
      if (i_wb_adr == 12'h020) c0w_q <= 1'b1;
    end
  end

  ack_wait_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus answer missing one cycle after request");
  ack_single_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("bus answer longer than one cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb && !o_wb_ack))
    else $error("bus answer without a request");
  unmapped_zero_a: assert property (
    o_wb_ack && $past(!i_wb_we && i_wb_adr == 12'h7FC) |-> o_wb_dat == 32'h0000_0000)
    else $error("unmapped read not zero");
  ram_sleep_a: assert property (
    o_wb_ack && pd_q && $past(!i_wb_we && i_wb_adr[11]) |-> o_wb_dat == 32'h0000_0000)
    else $error("array readable while powered down");
  conf0_reset_a: assert property (
    o_wb_ack && !c0w_q && $past(!i_wb_we && i_wb_adr == 12'h020) |->
    o_wb_dat == 32'h0100_0001) else $error("channel config reset value wrong");
  reset_quiet_a: assert property ($fell(i_rst) |-> o_pulse_en == 8'h00 && !o_wb_ack)
    else $error("outputs active after reset");
  owner_block_a: assert property (
    o_wb_ack && i_wb_we && i_wb_adr == 12'h03C && i_wb_dat[0] && i_wb_dat[2] &&
    !i_wb_dat[14] && !o_pulse_en[3] |=> (!o_pulse_en[3]) [*8])
    else $error("transmitter started without ownership");
endmodule // ptu_checker

bind ptu_top ptu_checker #(.CHANNELS(CHANNELS), .RAM_WORDS(RAM_WORDS)) ptu_checker_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
  .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ref_tick(i_ref_tick),
  .i_pulse_in(i_pulse_in), .o_pulse_out(o_pulse_out), .o_pulse_en(o_pulse_en));

// ### testbench/ptu_partner.sv
/*
  Infrared front-end model: records transmit runs and drives a receive line.
  Assumes the same clock as the unit; the line rests low as if pulled down.
*/
`timescale 1ns/1ps
module ptu_partner (
  // Clock
  input wire logic i_mclk,
  // Watched transmit pin
  input wire logic i_pulse,
  input wire logic i_pulse_en,
  // Receive line and run reports
  output logic o_line,
  output logic o_run_valid,
  output logic [15:0] o_run_data
);
  logic prev_en = 1'b0;
  logic prev_lv = 1'b0;
  logic [14:0] run_len = 15'h0001;
  initial o_line = 1'b0;
  initial o_run_valid = 1'b0;
  initial o_run_data = 16'h0000;

  // Run-length recorder; a run closes on a level change or on release
  always @(posedge i_mclk) begin
    o_run_valid <= 1'b0;
    if (i_pulse_en && prev_en && i_pulse == prev_lv) begin
      run_len <= run_len + 15'h0001;
    end else begin
      if (prev_en) begin
        o_run_valid <= 1'b1;
        o_run_data <= {prev_lv, run_len};
      end
      run_len <= 15'h0001;
    end
    prev_en <= i_pulse_en;
    prev_lv <= i_pulse;
  end

  // Emitter: a short glitch, a gap, then a real pulse, back to rest
  task automatic burst(input int g, input int gap, input int h);
    o_line <= 1'b1;
    repeat (g) @(posedge i_mclk);
    o_line <= 1'b0;
    repeat (gap) @(posedge i_mclk);
    o_line <= 1'b1;
    repeat (h) @(posedge i_mclk);
    o_line <= 1'b0;
  endtask
endmodule // ptu_partner

// ### testbench/ptu_top_tb_top.sv
/*
  Self-checking bench of the pulse-train unit: bus tasks, expectation queues, watcher.
  Assumes the unit, its checker and the front-end model are compiled with it.
*/
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (got), (exp)); end end
module ptu_top_tb_top;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wb_cyc = 1'b0;
  logic i_wb_stb = 1'b0;
  logic i_wb_we = 1'b0;
  logic [11:0] i_wb_adr = 12'h000;
  logic [3:0] i_wb_sel = 4'h0;
  logic [31:0] i_wb_dat = 32'h0000_0000;
  logic i_ref_tick = 1'b0;
  logic [31:0] o_wb_dat;
  logic o_wb_ack;
  logic [7:0] o_pulse_out;
  logic [7:0] o_pulse_en;
  logic line;
  logic run_valid;
  logic [15:0] run_data;
  logic [3:0] ref_cnt = 4'h0;
  logic [11:0] a;
  logic [31:0] rq;
  logic [31:0] seed = 32'h0000_f299;
  logic [63:0] rd_e;
  logic [31:0] run_e;
  logic [63:0] rd_q[$];
  logic [31:0] run_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int mul;

  // Unused receive inputs see their own transmit pins, so none is tied
  ptu_top ptu_top_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
    .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_ref_tick(i_ref_tick),
    .i_pulse_in({o_pulse_out[7:2], line, o_pulse_out[0]}), .o_pulse_out(o_pulse_out),
    .o_pulse_en(o_pulse_en));
  ptu_partner ptu_partner_inst (.i_mclk(i_mclk), .i_pulse(o_pulse_out[0]),
    .i_pulse_en(o_pulse_en[0]), .o_line(line), .o_run_valid(run_valid), .o_run_data(run_data));

  // Bus clock
  always #50 i_mclk = ~i_mclk;

  // Reference tick: one rising edge every ten cycles
  always @(posedge i_mclk) begin
    ref_cnt <= (ref_cnt == 4'h9) ? 4'h0 : ref_cnt + 4'h1;
    i_ref_tick <= (ref_cnt < 4'h5);
  end

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end

  // Watcher: every read answer and every reported run meets its oldest note
  always @(posedge i_mclk) begin
    if (o_wb_ack === 1'b1 && i_wb_we === 1'b0) begin
      rd_e = rd_q.pop_front();
      `CHK(o_wb_dat & rd_e[63:32], rd_e[31:0] & rd_e[63:32])
    end
    if (run_valid === 1'b1) begin
      run_e = run_q.size() ? run_q.pop_front() : 32'hFFFF_0000;
      `CHK(run_data & run_e[31:16], run_e[15:0] & run_e[31:16])
    end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Classic single cycle; held until ack is sampled, released at that edge
  task automatic wb(input logic we, input logic [11:0] ad, input logic [31:0] d);
    @(posedge i_mclk);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= we;
    i_wb_adr <= ad;
    i_wb_sel <= 4'hF;
    i_wb_dat <= d;
    @(posedge i_mclk);
    while (o_wb_ack !== 1'b1) @(posedge i_mclk);
    rq = o_wb_dat;
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] ad, input logic [31:0] e, input logic [31:0] m);
    rd_q.push_back({m, e});
    wb(1'b0, ad, 32'h0000_0000);
  endtask

  // Poll a busy bit; a mask of zero makes these reads match anything
  task automatic wait_clear(input logic [11:0] ad, input int b);
    for (int k = 0; k < 400; k++) begin
      rd(ad, 32'h0000_0000, 32'h0000_0000);
      if (rq[b] === 1'b0) break;
    end
    if (rq[b] !== 1'b0) mismatches++; // poll limit ran out
  endtask

  task end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(12'h020, 32'h0100_0001, 32'hFFFF_FFFF);
    rd(12'h024, 32'h0000_2000, 32'hFFFF_FFFF);
    rd(12'h0B0, 32'h0040_0040, 32'hFFFF_FFFF);
    rd(12'h0D0, 32'h0000_0080, 32'hFFFF_FFFF);
    rd(12'h0A0, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("Test done: reset values");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr_next(seed);
      a = 12'h800 + 12'(i * 256) + {4'h0, seed[7:2], 2'b00};
      wb(1'b1, a, seed);
      rd(a, seed, 32'hFFFF_FFFF);
    end
    wb(1'b1, 12'h7FC, 32'hFFFF_FFFF);
    rd(12'h7FC, 32'h0000_0000, 32'hFFFF_FFFF);
    wb(1'b1, 12'h0F0, 32'h0000_0001);
    rd(a, 32'h0000_0000, 32'hFFFF_FFFF);
    wb(1'b1, a, ~seed);
    wb(1'b1, 12'h0F0, 32'h0000_0000);
    rd(a, seed, 32'hFFFF_FFFF);
    $display("Test done: shared array");
    // Bus clock, divide by two, then reference tick; first run length is free after the first pass
    wb(1'b1, 12'h800, 32'h0002_8003);
    wb(1'b1, 12'h804, 32'h0000_8001);
    wb(1'b1, 12'h0D0, 32'h0000_0002);
    for (int i = 0; i < 3; i++) begin
      mul = (i == 0) ? 1 : ((i == 1) ? 2 : 10);
      run_q.push_back({(i == 0) ? 16'hFFFF : 16'h8000, 1'b1, 15'(3 * mul)});
      run_q.push_back({16'hFFFF, 1'b0, 15'(2 * mul)});
      run_q.push_back({16'hFFFF, 1'b1, 15'(mul)});
      wb(1'b1, 12'h020, (i == 1) ? 32'h0100_0002 : 32'h0100_0001);
      wb(1'b1, 12'h024, (i == 2) ? 32'h0000_0001 : 32'h0000_2001);
      wait_clear(12'h024, 16);
      rd(12'h024, 32'h0000_0000, 32'h0001_0001);
      rd(12'h0A0, 32'h0100_0001, 32'h0100_0001);
      wb(1'b1, 12'h0AC, 32'h0100_0001);
      rd(12'h0A0, 32'h0000_0000, 32'h0100_0001);
    end
    $display("Test done: transmit");
    wb(1'b1, 12'h034, 32'h0000_2002);
    wb(1'b1, 12'h03C, 32'h0000_2005);
    rd(12'h034, 32'h0000_0000, 32'h0000_0002);
    rd(12'h03C, 32'h0000_0000, 32'h0000_0001);
    wb(1'b1, 12'h0A8, 32'h0000_0100);
    rd(12'h0A0, 32'h0000_0900, 32'hFFFF_FFFF);
    rd(12'h0A4, 32'h0000_0100, 32'hFFFF_FFFF);
    wb(1'b1, 12'h0AC, 32'h0000_0900);
    rd(12'h0A0, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("Test done: ownership faults");
    // Receive on channel 1: filter of 8, idle limit of 48 ticks
    wb(1'b1, 12'h028, 32'h0100_3001);
    wb(1'b1, 12'h02C, 32'h0000_2116);
    ptu_partner_inst.burst(3, 4, 12);
    wait_clear(12'h02C, 17);
    rd(12'h0A0, 32'h0000_0010, 32'h0000_0010);
    rd(12'h02C, 32'h0000_0000, 32'h0000_0002);
    rd(12'h900, 32'h0000_8008, 32'h0000_FFF8);
    $display("Test done: receive");
    wb(1'b1, 12'h024, 32'h0000_E000);
    repeat (4) @(posedge i_mclk);
    `CHK({o_pulse_en[0], o_pulse_out[0]}, 2'b11)
    $display("Test done: idle output");
    end_sim();
  end
endmodule // ptu_top_tb_top
